// >>> mgpp_postproc.sv
// magnetometer post-processing, threshold events and register file
// Notes on behaviour
// - continuous cancel: alternate set/reset, average pairs
// - no cancel, rate bit 0: set every 63
// - no cancel, rate bit 1: set only from idle
// - single: invert polarity when both cancel bits set
// - six byte hard-iron registers at 45h-4Ah
// - subtract hard-iron value from each axis output
// - master enable and per-axis enables gate compare
// - 15-bit magnitude threshold, symmetric limits
// - crossings set axis flag and summary bit
// - no event while all data within limits
// - source select: raw or corrected data compared
// - pulsed pin follows crossing state
// - latched pin holds until source read
// - polarity bit picks active level of pin
// - range overflow flag latched only while master enable is set, cleared by read
// - temperature sensor runs only when enabled
// - temperature sampled with each measurement while enabled
// - temperature is 16-bit two's complement
// - byte-order bit swaps temperature bytes
// - self-test bit drives the coil current
// - single mode: one sample, then mode idle
`default_nettype none
`include "mgpp_cfg.svh"
module mgpp_postproc import mgpp_pkg::*; #(
   parameter logic [23:0] P_ODR0_CYC = 24'(`MGPP_CLK_HZ / `MGPP_ODR0_HZ),
   parameter logic [23:0] P_ODR1_CYC = 24'(`MGPP_CLK_HZ / `MGPP_ODR1_HZ),
   parameter logic [23:0] P_ODR2_CYC = 24'(`MGPP_CLK_HZ / `MGPP_ODR2_HZ),
   parameter logic [23:0] P_ODR3_CYC = 24'(`MGPP_CLK_HZ / `MGPP_ODR3_HZ)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port from the serial interface, same clock
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // converter control
   output logic meas_start,
   output logic sr_pulse,
   output logic sr_pol,
   output logic temp_sense_en,
   output logic coil_drive_en,
   // converter results, same clock
   input wire logic meas_done,
   input wire mgpp_word_t raw_x,
   input wire mgpp_word_t raw_y,
   input wire mgpp_word_t raw_z,
   input wire mgpp_word_t raw_temp,
   input wire logic range_ovf,
   // interrupt pin
   output logic irq_pin
);
   function automatic logic in_hi(input logic [7:0] a);
      in_hi = (a >= `MGPP_A_HI_FIRST) && (a <= `MGPP_A_HI_LAST);
   endfunction
   function automatic logic in_out(input logic [7:0] a);
      in_out = (a >= `MGPP_A_OUT_FIRST) && (a < `MGPP_A_TEMPL);
   endfunction

   mgpp_state_e state_ff, nxt_state;
   mgpp_mode_e md_ff;
   logic [7:0] hi_ff [6];
   logic [7:0] mode_ff, proc_ff, pin_ff, ictrl_ff, thl_ff, thh_ff, rdata_ff;
   logic [5:0] set_cnt_ff;
   logic first_ff, last_pol_ff, start_ff, pulse_ff, pol_ff, newdata_ff;
   logic [2:0] pos_ff, neg_ff;
   logic int_ff, exc_ff, ovf_ff, irq_out_ff;
   mgpp_word_t temp_ff;

   // register strobes
   wire logic wr_hi = reg_wr && in_hi(reg_addr);
   wire logic wr_mode = reg_wr && (reg_addr == `MGPP_A_MODE);
   wire logic rd_src = reg_rd && (reg_addr == `MGPP_A_ISRC);
   wire logic rd_stat = reg_rd && (reg_addr == `MGPP_A_STAT);
   wire logic [2:0] hi_idx = 3'(reg_addr - `MGPP_A_HI_FIRST);

   // configuration fields
   wire logic temp_en = mode_ff[`MGPP_B_TEMP_EN];
   wire logic [1:0] output_rate = mode_ff[3:2];
   wire logic offset_cancel_en = proc_ff[`MGPP_B_CANCEL];
   wire logic set_pulse_rate_sel = proc_ff[`MGPP_B_SETRATE];
   wire logic compare_corrected_sel = proc_ff[`MGPP_B_CMPCORR];
   wire logic single_shot_cancel_en = proc_ff[`MGPP_B_SSCANCEL];
   wire logic byte_swap_sel = pin_ff[`MGPP_B_SWAP];
   wire logic self_test = pin_ff[`MGPP_B_SELFTEST];
   wire logic irq_master_en = ictrl_ff[`MGPP_B_MASTER];
   wire logic irq_latch_sel = ictrl_ff[`MGPP_B_LATCH];
   wire logic irq_polarity_sel = ictrl_ff[`MGPP_B_POL];
   wire logic [2:0] axis_en = {ictrl_ff[5], ictrl_ff[6], ictrl_ff[7]};
   wire logic [14:0] ths = {thh_ff[6:0], thl_ff};

   // measurement sequencing
   wire logic md_cont = (md_ff == MD_CONT);
   wire logic md_single = (md_ff == MD_SINGLE);
   wire logic from_idle = (state_ff == S_IDLE);
   wire logic tick;
   wire logic start_now = (from_idle && (md_cont || md_single)) ||
                          (state_ff == S_ARM && md_cont && tick);
   wire logic done_ok = meas_done && (state_ff == S_BUSY);
   wire logic cancel_c = md_cont && offset_cancel_en;
   wire logic dual_s = md_single && offset_cancel_en && single_shot_cancel_en;
   wire logic set_due = (set_cnt_ff == `MGPP_SET_PERIODS - 6'd1);
   wire logic nxt_pulse = cancel_c || md_single || from_idle ||
                          (!set_pulse_rate_sel && set_due);
   wire logic nxt_pol = ((cancel_c && !from_idle) || dual_s) ? ~last_pol_ff : 1'b1;
   wire logic avg_en = cancel_c && !first_ff;
   wire logic out_en = !(cancel_c && first_ff);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (start_now) nxt_state = S_BUSY;
         end
         S_BUSY: begin
            if (done_ok) nxt_state = md_single ? S_IDLE : S_ARM;
         end
         default: begin
            if (!md_cont) nxt_state = S_IDLE;
            else if (start_now) nxt_state = S_BUSY;
         end
      endcase
   end

   mgpp_rate_timer #(
      .P_CYC0(P_ODR0_CYC),
      .P_CYC1(P_ODR1_CYC),
      .P_CYC2(P_ODR2_CYC),
      .P_CYC3(P_ODR3_CYC)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .run(!from_idle && md_cont),
      .rate(output_rate),
      .tick(tick)
   );

   // axes
   wire mgpp_word_t raw_w [3];
   wire mgpp_word_t hi_w [3];
   wire mgpp_word_t out_w [3];
   wire logic [2:0] vld_w, pos_w, neg_w;
   assign raw_w[0] = raw_x;
   assign raw_w[1] = raw_y;
   assign raw_w[2] = raw_z;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_axis
         assign hi_w[g] = {hi_ff[2 * g + 1], hi_ff[2 * g]};
         mgpp_axis u_axis (
            .clk(clk),
            .rst(rst),
            .raw_vld(done_ok),
            .out_en(out_en),
            .avg_en(avg_en),
            .raw(raw_w[g]),
            .hard_iron(hi_w[g]),
            .ths(ths),
            .cmp_corr(compare_corrected_sel),
            .out_val(out_w[g]),
            .vld(vld_w[g]),
            .pos(pos_w[g]),
            .neg(neg_w[g])
         );
      end
   endgenerate

   // threshold events
   wire logic sample_new = vld_w[0];
   wire logic [2:0] gate = irq_master_en ? axis_en : 3'b000;
   wire logic [2:0] cur_pos = pos_w & gate;
   wire logic [2:0] cur_neg = neg_w & gate;
   wire logic cur_exc = |{cur_pos, cur_neg};
   wire logic [2:0] base_pos = rd_src ? 3'b000 : pos_ff;
   wire logic [2:0] base_neg = rd_src ? 3'b000 : neg_ff;
   wire logic base_int = !rd_src && int_ff;
   wire logic keep = irq_latch_sel;
   wire logic [2:0] nxt_pos = sample_new ? ((keep ? base_pos : 3'b000) | cur_pos) : base_pos;
   wire logic [2:0] nxt_neg = sample_new ? ((keep ? base_neg : 3'b000) | cur_neg) : base_neg;
   wire logic nxt_int = sample_new ? ((keep && base_int) || cur_exc) : base_int;
   wire logic ovf_set = done_ok && range_ovf && irq_master_en;
   wire logic int_active = irq_latch_sel ? int_ff : exc_ff;
   // axis x sits in the top bit of each flag group
   wire logic [7:0] src_val = {pos_ff[0], pos_ff[1], pos_ff[2], neg_ff[0], neg_ff[1], neg_ff[2], ovf_ff, int_ff};
   wire mgpp_word_t temp_rd = byte_swap_sel ? {temp_ff[7:0], temp_ff[15:8]} : temp_ff;
   wire logic [2:0] out_idx = 3'(reg_addr - `MGPP_A_OUT_FIRST);
   wire mgpp_word_t out_sel = out_w[out_idx[2:1]];

   logic [7:0] rd_mux;
   always_comb begin
      if (in_hi(reg_addr)) rd_mux = hi_ff[hi_idx];
      else if (in_out(reg_addr)) rd_mux = out_idx[0] ? out_sel[15:8] : out_sel[7:0];
      else if (reg_addr == `MGPP_A_MODE) rd_mux = {mode_ff[7:2], md_ff};
      else if (reg_addr == `MGPP_A_PROC) rd_mux = proc_ff;
      else if (reg_addr == `MGPP_A_PIN) rd_mux = pin_ff;
      else if (reg_addr == `MGPP_A_ICTRL) rd_mux = ictrl_ff;
      else if (reg_addr == `MGPP_A_ISRC) rd_mux = src_val;
      else if (reg_addr == `MGPP_A_THL) rd_mux = thl_ff;
      else if (reg_addr == `MGPP_A_THH) rd_mux = {1'b0, thh_ff[6:0]};
      else if (reg_addr == `MGPP_A_STAT) rd_mux = {4'h0, newdata_ff, 3'b000};
      else if (reg_addr == `MGPP_A_TEMPL) rd_mux = temp_rd[7:0];
      else if (reg_addr == `MGPP_A_TEMPH) rd_mux = temp_rd[15:8];
      else rd_mux = 8'h00;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= `MGPP_R_ZERO;
         md_ff <= MD_IDLE;
         proc_ff <= `MGPP_R_ZERO;
         pin_ff <= `MGPP_R_ZERO;
         ictrl_ff <= `MGPP_R_ZERO;
         thl_ff <= `MGPP_R_ZERO;
         thh_ff <= `MGPP_R_ZERO;
      end else begin
         if (wr_mode) begin
            mode_ff <= reg_wdata;
            md_ff <= mgpp_mode_e'((reg_wdata[1:0] == 2'b10) ? 2'b11 : reg_wdata[1:0]);
         end else if (done_ok && md_single) begin
            md_ff <= MD_IDLE;
         end
         if (reg_wr && reg_addr == `MGPP_A_PROC) proc_ff <= reg_wdata;
         if (reg_wr && reg_addr == `MGPP_A_PIN) pin_ff <= reg_wdata;
         if (reg_wr && reg_addr == `MGPP_A_ICTRL) ictrl_ff <= reg_wdata;
         if (reg_wr && reg_addr == `MGPP_A_THL) thl_ff <= reg_wdata;
         if (reg_wr && reg_addr == `MGPP_A_THH) thh_ff <= reg_wdata;
      end
   end

   generate
      for (g = 0; g < 6; g++) begin : g_hi
         always_ff @(posedge clk) begin
            if (rst) hi_ff[g] <= `MGPP_R_ZERO;
            else if (wr_hi && hi_idx == 3'(g)) hi_ff[g] <= reg_wdata;
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= S_IDLE;
         set_cnt_ff <= 6'h00;
         first_ff <= 1'b0;
         last_pol_ff <= 1'b0;
         start_ff <= 1'b0;
         pulse_ff <= 1'b0;
         pol_ff <= 1'b0;
         temp_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         start_ff <= start_now;
         if (start_now) begin
            pulse_ff <= nxt_pulse;
            pol_ff <= nxt_pol;
            last_pol_ff <= nxt_pol;
            first_ff <= from_idle ? 1'b1 : first_ff;
            set_cnt_ff <= (from_idle || set_due) ? 6'h00 : set_cnt_ff + 6'd1;
         end else if (done_ok) begin
            first_ff <= 1'b0;
         end
         if (done_ok && temp_en) temp_ff <= raw_temp;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos_ff <= 3'b000;
         neg_ff <= 3'b000;
         int_ff <= 1'b0;
         exc_ff <= 1'b0;
         ovf_ff <= 1'b0;
         newdata_ff <= 1'b0;
         irq_out_ff <= 1'b1;
         rdata_ff <= 8'h00;
      end else begin
         pos_ff <= nxt_pos;
         neg_ff <= nxt_neg;
         int_ff <= nxt_int;
         if (!irq_master_en) exc_ff <= 1'b0;
         else if (sample_new) exc_ff <= cur_exc;
         ovf_ff <= ovf_set || (ovf_ff && !rd_src);
         newdata_ff <= sample_new || (newdata_ff && !rd_stat);
         irq_out_ff <= irq_polarity_sel ? int_active : ~int_active;
         if (reg_rd) rdata_ff <= rd_mux;
      end
   end

   assign reg_rdata = rdata_ff;
   assign meas_start = start_ff;
   assign sr_pulse = pulse_ff && start_ff;
   assign sr_pol = pol_ff;
   assign temp_sense_en = temp_en;
   assign coil_drive_en = self_test;
   assign irq_pin = irq_out_ff;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_alt;
      (start_now && cancel_c && !from_idle) |=> sr_pulse && sr_pol != $past(last_pol_ff);
   endproperty
   a_alt: assert property (p_alt) else $error("cancel pulses do not alternate");
   property p_set63;
      (start_now && md_cont && !offset_cancel_en && !set_pulse_rate_sel && !from_idle)
         |=> sr_pulse == ($past(set_cnt_ff) == 6'd62);
   endproperty
   a_set63: assert property (p_set63) else $error("periodic set pulse misplaced");
   property p_setonce;
      (start_now && md_cont && !offset_cancel_en && set_pulse_rate_sel && !from_idle) |=> !sr_pulse;
   endproperty
   a_setonce: assert property (p_setonce) else $error("set pulse outside start from idle");
   property p_single_pol;
      (start_now && dual_s) |=> sr_pol != $past(last_pol_ff);
   endproperty
   a_single_pol: assert property (p_single_pol) else $error("single polarity not inverted");
   sequence s_single_done;
      done_ok && md_single && !wr_mode;
   endsequence
   property p_idle_ret;
      s_single_done |=> md_ff == MD_IDLE && state_ff == S_IDLE;
   endproperty
   a_idle_ret: assert property (p_idle_ret) else $error("single mode did not return idle");
   property p_master;
      (sample_new && !irq_master_en && (rd_src || (pos_ff == 3'b000 && neg_ff == 3'b000)))
         |=> pos_ff == 3'b000 && neg_ff == 3'b000 && !exc_ff;
   endproperty
   a_master: assert property (p_master) else $error("flag set with master disabled");
   property p_ovf;
      (done_ok && range_ovf && irq_master_en) |=> ovf_ff ##1 (ovf_ff || $past(rd_src));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag not latched");
   sequence s_quiet_sample;
      sample_new && irq_master_en && !irq_latch_sel && !cur_exc && irq_polarity_sel;
   endsequence
   property p_pulsed;
      s_quiet_sample ##1 !irq_latch_sel && irq_polarity_sel |=> !irq_pin;
   endproperty
   a_pulsed: assert property (p_pulsed) else $error("pulsed pin stays active");
   property p_latch;
      (int_ff && irq_latch_sel && !rd_src) |=> int_ff;
   endproperty
   a_latch: assert property (p_latch) else $error("latched event lost before read");
   property p_pol;
      (int_active && !irq_polarity_sel) [*2] |-> !irq_pin;
   endproperty
   a_pol: assert property (p_pol) else $error("active-low pin not low");
   property p_rdclr;
      (rd_src && !sample_new && !ovf_set) |=> src_val == 8'h00;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("source read did not clear");
endmodule // mgpp_postproc
`default_nettype wire

// >>> mgpp_cfg.svh
// constants of the magnetometer post-processing block
`ifndef MGPP_CFG_SVH
`define MGPP_CFG_SVH
`define MGPP_CLK_HZ 125_000_000
`define MGPP_ODR0_HZ 10
`define MGPP_ODR1_HZ 20
`define MGPP_ODR2_HZ 50
`define MGPP_ODR3_HZ 100
`define MGPP_SET_PERIODS 6'h3F
// register offsets
`define MGPP_A_HI_FIRST 8'h45
`define MGPP_A_HI_LAST 8'h4A
`define MGPP_A_MODE 8'h60
`define MGPP_A_PROC 8'h61
`define MGPP_A_PIN 8'h62
`define MGPP_A_ICTRL 8'h63
`define MGPP_A_ISRC 8'h64
`define MGPP_A_THL 8'h65
`define MGPP_A_THH 8'h66
`define MGPP_A_STAT 8'h67
`define MGPP_A_OUT_FIRST 8'h68
`define MGPP_A_TEMPL 8'h6E
`define MGPP_A_TEMPH 8'h6F
// reset values
`define MGPP_R_MODE 8'h03
`define MGPP_R_ZERO 8'h00
// field positions
`define MGPP_B_TEMP_EN 7
`define MGPP_B_CANCEL 1
`define MGPP_B_SETRATE 2
`define MGPP_B_CMPCORR 3
`define MGPP_B_SSCANCEL 4
`define MGPP_B_SELFTEST 1
`define MGPP_B_SWAP 4
`define MGPP_B_MASTER 0
`define MGPP_B_LATCH 1
`define MGPP_B_POL 2
`endif

// >>> mgpp_pkg.sv
// types of the magnetometer post-processing block
`default_nettype none
package mgpp_pkg;
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_BUSY = 2'b01, S_ARM = 2'b11} mgpp_state_e;
   typedef enum logic [1:0] {MD_CONT = 2'b00, MD_SINGLE = 2'b01, MD_IDLE = 2'b11} mgpp_mode_e;
   typedef logic [15:0] mgpp_word_t;
endpackage
`default_nettype wire

// >>> mgpp_rate_timer.sv
// output-rate tick generator
`default_nettype none
`include "mgpp_cfg.svh"
module mgpp_rate_timer import mgpp_pkg::*; #(
   parameter logic [23:0] P_CYC0 = 24'd12_500_000,
   parameter logic [23:0] P_CYC1 = 24'd6_250_000,
   parameter logic [23:0] P_CYC2 = 24'd2_500_000,
   parameter logic [23:0] P_CYC3 = 24'd1_250_000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic [1:0] rate,
   // tick
   output logic tick
);
   logic [23:0] cnt_ff;
   logic tick_ff;
   wire logic [23:0] period = (rate == 2'd0) ? P_CYC0 : (rate == 2'd1) ? P_CYC1 :
                              (rate == 2'd2) ? P_CYC2 : P_CYC3;
   wire logic wrap = (cnt_ff >= period - 24'd1);
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_ff <= 24'h0000;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= wrap ? 24'h0000 : cnt_ff + 24'd1;
         tick_ff <= wrap;
      end
   end
   assign tick = tick_ff;
   property p_tick_gap;
      @(posedge clk) disable iff (rst) tick |=> !tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("rate tick longer than one cycle");
endmodule // mgpp_rate_timer
`default_nettype wire

// >>> mgpp_axis.sv
// one axis: pair averaging, hard-iron subtraction, threshold compare
`default_nettype none
module mgpp_axis import mgpp_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // sample in
   input wire logic raw_vld,
   input wire logic out_en,
   input wire logic avg_en,
   input wire mgpp_word_t raw,
   // configuration
   input wire mgpp_word_t hard_iron,
   input wire logic [14:0] ths,
   input wire logic cmp_corr,
   // result
   output mgpp_word_t out_val,
   output logic vld,
   output logic pos,
   output logic neg
);
   mgpp_word_t prev_ff, out_ff;
   logic vld_ff, pos_ff, neg_ff;
   wire logic signed [16:0] sum = {raw[15], raw} + {prev_ff[15], prev_ff};
   wire mgpp_word_t meas = avg_en ? sum[16:1] : raw;
   // subtraction wraps, same as the converter's own 16-bit range
   wire mgpp_word_t corr = meas - hard_iron;
   wire logic signed [16:0] cmp = cmp_corr ? {corr[15], corr} : {meas[15], meas};
   wire logic signed [16:0] lim = {2'b00, ths};
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_ff <= 16'h0000;
         out_ff <= 16'h0000;
         vld_ff <= 1'b0;
         pos_ff <= 1'b0;
         neg_ff <= 1'b0;
      end else begin
         vld_ff <= raw_vld && out_en;
         if (raw_vld) begin
            prev_ff <= raw;
         end
         if (raw_vld && out_en) begin
            out_ff <= corr;
            pos_ff <= cmp > lim;
            neg_ff <= cmp < -lim;
         end
      end
   end
   assign out_val = out_ff;
   assign vld = vld_ff;
   assign pos = pos_ff;
   assign neg = neg_ff;
   property p_sub;
      @(posedge clk) disable iff (rst)
         (raw_vld && out_en && !avg_en) |=> out_ff == mgpp_word_t'($past(raw) - $past(hard_iron));
   endproperty
   a_sub: assert property (p_sub) else $error("hard-iron value not subtracted");
endmodule // mgpp_axis
`default_nettype wire

// >>> mgpp_conv_model.sv
// converter model: answers each start after a short or a long conversion
`default_nettype none
module mgpp_conv_model import mgpp_pkg::*; (
   // clock
   input wire logic clk,
   // scene set by the bench
   input wire logic slow,
   input wire mgpp_word_t field,
   input wire mgpp_word_t hoff,
   input wire mgpp_word_t temp,
   input wire logic ovf,
   // converter link
   input wire logic meas_start,
   input wire logic sr_pulse,
   input wire logic sr_pol,
   input wire logic coil,
   output logic meas_done,
   output mgpp_word_t raw_x,
   output mgpp_word_t raw_temp,
   output logic range_ovf
);
   logic [3:0] cnt = 4'h0;
   logic busy = 1'b0;
   logic pol = 1'b1;
   mgpp_word_t val;
   // sensor offset flips sign with the set/reset pulse
   // self-test coil adds a fixed field on every axis
   assign val = (pol ? field + hoff : field - hoff) + (coil ? 16'h0100 : 16'h0000);
   // outside the done cycle the lines show junk, never the sample
   assign raw_x = meas_done ? val : ~val;
   assign raw_temp = meas_done ? temp : ~temp;
   assign range_ovf = meas_done ? ovf : ~ovf;
   initial meas_done = 1'b0;
   always @(posedge clk) begin
      meas_done <= 1'b0;
      if (meas_start) begin
         busy <= 1'b1;
         cnt <= slow ? 4'h9 : 4'h1;
         if (sr_pulse) pol <= sr_pol;
      end else if (busy && cnt == 4'h0) begin
         busy <= 1'b0;
         meas_done <= 1'b1;
      end else if (busy) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule // mgpp_conv_model
`default_nettype wire

// >>> mgpp_postproc_test.sv
// self-checking bench for the magnetometer post-processing block
`default_nettype none
`include "mgpp_cfg.svh"
module mgpp_postproc_test import mgpp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic meas_start, sr_pulse, sr_pol, temp_sense_en, coil_drive_en, meas_done, range_ovf, irq_pin;
   mgpp_word_t raw_x, raw_temp, rw;
   logic slow = 1'b0;
   logic ovf = 1'b0;
   mgpp_word_t field = 16'h0000;
   mgpp_word_t hoff = 16'h0000;
   mgpp_word_t temp = 16'h1234;
   mgpp_word_t hi [3] = '{16'h0100, 16'h1234, 16'hABCD};
   int n_errors = 0;
   int n_checks = 0;
   int n_done = 0;
   int n_pulse = 0;
   int pulse_at = 0;
   logic last_pol = 1'b0;
   logic [7:0] rv;

   initial forever #4 clk = ~clk;

   mgpp_postproc #(.P_ODR0_CYC(24'd40), .P_ODR1_CYC(24'd30), .P_ODR2_CYC(24'd20), .P_ODR3_CYC(24'd10)) dut (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .meas_start(meas_start), .sr_pulse(sr_pulse), .sr_pol(sr_pol),
      .temp_sense_en(temp_sense_en), .coil_drive_en(coil_drive_en), .meas_done(meas_done), .raw_x(raw_x),
      .raw_y(raw_x), .raw_z(raw_x), .raw_temp(raw_temp), .range_ovf(range_ovf), .irq_pin(irq_pin));
   mgpp_conv_model conv (.clk(clk), .slow(slow), .field(field), .hoff(hoff), .temp(temp), .ovf(ovf),
      .meas_start(meas_start), .sr_pulse(sr_pulse), .sr_pol(sr_pol), .meas_done(meas_done), .raw_x(raw_x),
      .raw_temp(raw_temp), .range_ovf(range_ovf), .coil(coil_drive_en));

   always @(posedge clk) begin
      if (meas_done) n_done <= n_done + 1;
      if (sr_pulse) begin
         last_pol <= sr_pol;
         n_pulse <= n_pulse + 1;
         pulse_at <= n_done;
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // let the written register settle before callers look at outputs
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1 rv = reg_rdata;
   endtask
   task automatic rd16(input logic [7:0] a);
      rd(a);
      rw[7:0] = rv;
      rd(a + 8'h01);
      rw[15:8] = rv;
   endtask
   // one single-mode request; exactly one conversion may answer it
   task automatic shot();
      int n;
      n = n_done;
      wr(`MGPP_A_MODE, 8'h81);
      for (int i = 0; i < 40 && n_done == n; i++) @(posedge clk);
      repeat (6) @(posedge clk);
      chk(16'(n_done - n), 16'h0001, "one conversion per request");
   endtask

   task automatic t_regs();
      rd(`MGPP_A_MODE);
      chk(rv, `MGPP_R_MODE, "mode after reset");
      rd(8'h50);
      chk(rv, 8'h00, "unmapped read");
      for (int i = 0; i < 3; i++) begin
         wr(`MGPP_A_HI_FIRST + 8'(2 * i), hi[i][7:0]);
         wr(`MGPP_A_HI_FIRST + 8'(2 * i + 1), hi[i][15:8]);
      end
      wr(`MGPP_A_ISRC, 8'hFF);
      field = 16'h0200;
      shot();
      chk(temp_sense_en, 1'b1, "temperature sensor on");
      for (int i = 0; i < 3; i++) begin
         rd16(`MGPP_A_HI_FIRST + 8'(2 * i));
         chk(rw, hi[i], "hard-iron readback");
         rd16(`MGPP_A_OUT_FIRST + 8'(2 * i));
         chk(rw, field - hi[i], "corrected output");
      end
      rd(`MGPP_A_MODE);
      chk(rv, 8'h83, "mode back to idle");
      rd(`MGPP_A_ISRC);
      chk(rv, 8'h00, "no flags without master enable");
      rd16(`MGPP_A_TEMPL);
      chk(rw, temp, "temperature word");
      wr(`MGPP_A_PIN, 8'h12);
      chk(coil_drive_en, 1'b1, "coil on");
      rd16(`MGPP_A_TEMPL);
      chk(rw, 16'h3412, "swapped temperature");
      wr(`MGPP_A_PIN, 8'h00);
      chk(coil_drive_en, 1'b0, "coil off");
   endtask
   task automatic t_latch();
      wr(`MGPP_A_THL, 8'h80);
      wr(`MGPP_A_ICTRL, 8'h87);
      field = 16'h0081;
      ovf = 1'b1;
      shot();
      chk(irq_pin, 1'b1, "latched pin raised");
      field = 16'h0000;
      ovf = 1'b0;
      shot();
      chk(irq_pin, 1'b1, "latched pin holds in range");
      rd(`MGPP_A_ISRC);
      chk(rv, 8'h83, "x positive, overflow, summary");
      repeat (3) @(posedge clk);
      chk(irq_pin, 1'b0, "pin cleared by source read");
      rd(`MGPP_A_ISRC);
      chk(rv, 8'h00, "flags cleared by read");
      wr(`MGPP_A_PROC, 8'h08);
      field = 16'h0081;
      shot();
      rd(`MGPP_A_ISRC);
      chk(rv, 8'h00, "corrected data within limits");
      wr(`MGPP_A_PROC, 8'h00);
   endtask
   task automatic t_pulse();
      wr(`MGPP_A_ICTRL, 8'h81);
      field = 16'hFF7F;
      shot();
      chk(irq_pin, 1'b0, "active-low pulsed pin");
      rd(`MGPP_A_ISRC);
      chk(rv, 8'h11, "x negative and summary");
      field = 16'hFF80;
      shot();
      chk(irq_pin, 1'b1, "pin drops back at limit");
   endtask
   task automatic t_pol();
      logic p0;
      mgpp_word_t a0;
      hoff = 16'h0040;
      field = 16'h0123;
      wr(`MGPP_A_PROC, 8'h12);
      shot();
      p0 = last_pol;
      rd16(`MGPP_A_OUT_FIRST);
      a0 = rw;
      shot();
      chk(last_pol, {~p0}, "polarity inverts between shots");
      rd16(`MGPP_A_OUT_FIRST);
      chk(a0 + rw, (field - hi[0]) << 1, "host pair average cancels offset");
      wr(`MGPP_A_PROC, 8'h02);
      shot();
      shot();
      chk(last_pol, 1'b1, "set pulse without one-shot cancel");
   endtask
   task automatic t_cont();
      int n;
      slow = 1'b1;
      hoff = 16'h0040;
      field = 16'h0123;
      n = n_done;
      wr(`MGPP_A_MODE, 8'h80);
      for (int i = 0; i < 400 && n_done < n + 4; i++) @(posedge clk);
      wr(`MGPP_A_MODE, 8'h83);
      repeat (20) @(posedge clk);
      rd16(`MGPP_A_OUT_FIRST);
      chk(rw, field - hi[0], "pair average cancels offset");
   endtask

   task automatic t_self();
      int s[2];
      for (int b = 0; b < 2; b++) begin
         s[b] = 0;
         wr(`MGPP_A_PIN, 8'(2 * b));
         repeat (50) begin
            shot();
            rd16(`MGPP_A_OUT_FIRST);
            s[b] += $signed(rw);
         end
      end
      wr(`MGPP_A_PIN, 8'h00);
      chk(16'((s[1] - s[0]) / 50), 16'h0100, "self-test block difference");
   endtask
   task automatic t_setrate();
      int n;
      int p;
      slow = 1'b0;
      field = 16'h0000;
      wr(`MGPP_A_ICTRL, 8'h85);
      for (int k = 0; k < 2; k++) begin
         wr(`MGPP_A_PROC, k ? 8'h00 : 8'h04);
         n = n_done;
         p = n_pulse;
         wr(`MGPP_A_MODE, 8'h8C);
         for (int i = 0; i < 900 && n_done < n + 66; i++) @(posedge clk);
         wr(`MGPP_A_MODE, 8'h83);
         repeat (20) @(posedge clk);
         chk(16'(n_pulse - p), k ? 16'h0002 : 16'h0001, "set pulses in continuous run");
         if (k) chk(16'(pulse_at - n), 16'd63, "periodic set pulse spacing");
      end
      chk(irq_pin, 1'b0, "active-high pulsed pin idle");
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_self();
      t_latch();
      t_pulse();
      t_pol();
      t_cont();
      t_setrate();
      finish_test();
   end
endmodule // mgpp_postproc_test
`default_nettype wire
